// file: hw/gsof_pkg.sv
// Purpose: constants and types shared by the setup, framing and bus-slave logic
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes: setup word layout is fixed here; slot stores are word-wide
package gsof_pkg;
  // register byte offsets
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_CMD = 5'h04;
  localparam logic [4:0] ADR_SETUP = 5'h08;
  localparam logic [4:0] ADR_CABLE = 5'h0c;
  localparam logic [4:0] ADR_DRIFT = 5'h10;
  localparam logic [4:0] ADR_STAT = 5'h14;
  localparam logic [4:0] ADR_TX = 5'h18;
  // field positions
  localparam int CTRL_TERM_LSB = 0;
  localparam int CTRL_K_LSB = 4;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SLOT_LSB = 4;
  localparam int CMD_Q_LSB = 8;
  localparam int TX_LAST_BIT = 8;
  localparam int ST_RANGE_ERR = 0;
  localparam int ST_LOCK_ERR = 1;
  localparam int ST_K_ERR = 2;
  localparam int ST_CBL_EN = 3;
  localparam int ST_READY = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_DRIFT_OK = 6;
  localparam int ST_OUT_DONE = 7;
  localparam int ST_TX_BUSY = 8;
  localparam int ST_CSLOT_LSB = 12;
  // commands
  typedef enum logic [2:0] {
    OP_RCL_SET = 3'h0, OP_SAV_SET = 3'h1, OP_RCL_CBL = 3'h2,
    OP_SAV_CBL = 3'h3, OP_CAL = 3'h4, OP_DONE = 3'h5
  } gsof_op_t;
  // terminator codes and characters
  localparam logic [1:0] TERM_CRLF = 2'h0;
  localparam logic [1:0] TERM_LFCR = 2'h1;
  localparam logic [1:0] TERM_LF = 2'h3;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  // eoi / hold-off codes
  localparam logic [2:0] K_BOTH = 3'h0;
  localparam logic [2:0] K_NOEOI = 3'h1;
  localparam logic [2:0] K_NOHOLD = 3'h2;
  localparam logic [2:0] K_NONE = 3'h4;
  // setup word: range[2:0] freq[4:3] filter[5] rate[8:6] zero[9] trig[13:10]
  // bias_on[14] wave[17:15] wtimes[23:18] biasv[31:24]
  localparam int SET_W = 32;
  localparam int FREQ_LSB = 3;
  localparam logic [SET_W-1:0] FREQ_MASK = 32'h0000_0018;
  localparam logic [SET_W-1:0] FREQ_100K = 32'h0000_0000;
  localparam logic [SET_W-1:0] FACTORY_SETUP = 32'h0000_0000;
  localparam logic [SET_W-1:0] RESET_SETUP = 32'h0000_0000;
  localparam logic [2:0] DFLT_SLOT = 3'h1;
  localparam logic [3:0] Q_LOCK_MIN = 4'h1;
  localparam logic [3:0] Q_LOCK_MAX = 4'h9;
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_READ = 3'b010, S_LOAD = 3'b100} gsof_st_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_DATA = 4'b0010, TX_TERM1 = 4'b0100, TX_TERM2 = 4'b1000
  } gsof_tx_t;
endpackage : gsof_pkg

// file: hw/gsof_slot_mem.sv
// Purpose: small slot store with registered read data
// Assumes: one write and one read port, same clock
// Notes: stands in for the nonvolatile setup store; whole-word writes only
module gsof_slot_mem #(
  parameter int W = 32,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic i_clk, // clock
  input wire logic i_ce, // clock enable
  input wire logic i_we, // write strobe
  input wire logic [AW-1:0] i_waddr, // write slot
  input wire logic [W-1:0] i_wdata, // write word
  input wire logic [AW-1:0] i_raddr, // read slot
  output logic [W-1:0] o_rdata // registered read word
);
  // store starts blank, so a slot never saved recalls as zeros rather than unknowns
  logic [W-1:0] mem_r [D] = '{default: '0};

  // one word per slot, so a save is never half done
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule : gsof_slot_mem

// file: hw/gsof_top.sv
// Purpose: setup/cable slot handling, calibration lock, output framing, hold-off
// Assumes: command parsing done by software, talker bytes handshaken by the bus engine
// Notes: registers on classic wishbone, one-cycle ack
// Contract
// - setup recall slots 0-7, setup save slots 1-7 only.
// - power-up and device clear load setup slot 1 as active setup.
// - setup slot 0 is fixed factory data, never written by save.
// - a slot saves and restores the whole active setup word.
// - recalling setup slot 0 forces frequency to 100kHz.
// - cable slots recall 0-7, save 1-7; recall 0 disables external correction.
// - cable slot 0 selected, external correction off, after reset and device clear.
// - calibration commands 1-9 rejected with lock error while switch locked.
// - device clear discards stored drift correction constants.
// - terminator codes 0 CRLF, 1 LFCR, 2 CR, 3 LF.
// - reset and device clear return terminator to CR then LF.
// - terminator follows every status word and data string.
// - terminator sent once, only after final byte of a transmission.
// - with EOI enabled, EOI rides on the last terminator byte.
// - EOI/hold-off code 0 both, 1 hold only, 2 EOI only, 4 neither.
// - reset and device clear enable both EOI and hold-off.
// - with hold-off enabled NRFD held from execute until processing done.
// - ready status bit 4 set when processed, cleared while processing.
// - a whole buffer transmission gets EOI only once at its end.
module gsof_top
  import gsof_pkg::*;
(
  input wire logic I_MCLK, // 50 MHz clock
  input wire logic I_RST, // sync reset, high
  input wire logic I_CE, // clock enable
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic I_WB_WE, // wishbone write
  input wire logic [4:0] I_WB_ADR, // byte address
  input wire logic [31:0] I_WB_DAT, // write data
  input wire logic [3:0] I_WB_SEL, // byte lanes
  output logic [31:0] O_WB_DAT, // read data
  output logic O_WB_ACK, // acknowledge
  input wire logic I_EXEC, // execute character received, pulse
  input wire logic I_DEV_CLR, // dcl or sdc received, pulse
  input wire logic I_CAL_UNLOCK, // calibration switch, high = unlocked
  output logic O_NRFD, // bus hold-off, high = asserted
  output logic O_READY, // all commands processed
  output logic O_TX_VALID, // talker byte valid
  output logic [7:0] O_TX_DATA, // talker byte
  output logic O_TX_EOI, // eoi with this byte
  input wire logic I_TX_READY, // bus engine takes byte
  output logic [31:0] O_SETUP, // active setup word
  output logic [31:0] O_CABLE, // active cable constants
  output logic O_CABLE_EN, // external cable correction on
  output logic O_CAL_GO, // calibration step start, pulse
  output logic [3:0] O_CAL_NUM // calibration step number
);
  gsof_st_t st_r, st_nxt;
  gsof_tx_t tx_r, tx_nxt;
  logic [1:0] term_r, term_nxt;
  logic [2:0] k_r, k_nxt, slot_r, slot_nxt, cslot_r, cslot_nxt;
  logic cbl_r, cbl_nxt, ready_r, ready_nxt, nrfd_r, nrfd_nxt, cen_r, cen_nxt;
  logic [31:0] setup_r, setup_nxt, cable_r, cable_nxt, drift_r, drift_nxt, dat_r, dat_nxt;
  logic rerr_r, rerr_nxt, lerr_r, lerr_nxt, kerr_r, kerr_nxt, dok_r, dok_nxt;
  logic ack_r, ack_nxt, go_r, go_nxt, done_r, done_nxt;
  logic [3:0] qn_r, qn_nxt;
  logic [7:0] txb_r, txb_nxt, odat_r, odat_nxt;
  logic txl_r, txl_nxt, ovld_r, ovld_nxt, oeoi_r, oeoi_nxt;
  logic req, wr, clr, cmd_wr, hold_en, eoi_en, set_we, cbl_we, xfer, single;
  logic [31:0] wmask, set_rd, cbl_rd;
  logic [2:0] cslot;
  logic [3:0] cq;
  gsof_op_t cop;
  logic [7:0] term1, term2;

  // bus decode and option decode
  assign req = I_WB_CYC & I_WB_STB & ~ack_r;
  assign wr = req & I_WB_WE;
  assign clr = I_RST | I_DEV_CLR;
  assign cmd_wr = wr & (I_WB_ADR == ADR_CMD) & I_WB_SEL[0];
  assign cop = gsof_op_t'(I_WB_DAT[CMD_OP_LSB +: 3]);
  assign cslot = I_WB_DAT[CMD_SLOT_LSB +: 3];
  assign cq = I_WB_DAT[CMD_Q_LSB +: 4];
  assign wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  assign hold_en = (k_r == K_BOTH) | (k_r == K_NOEOI);
  assign eoi_en = (k_r == K_BOTH) | (k_r == K_NOHOLD);
  // saves only in idle and never to slot 0, which is the factory image
  assign set_we = cmd_wr & (st_r == S_IDLE) & (cop == OP_SAV_SET) & (cslot != 3'h0);
  assign cbl_we = cmd_wr & (st_r == S_IDLE) & (cop == OP_SAV_CBL) & (cslot != 3'h0);
  assign xfer = ovld_r & I_TX_READY;
  assign single = term_r[1];
  assign term1 = (term_r == TERM_LFCR || term_r == TERM_LF) ? CHR_LF : CHR_CR;
  assign term2 = (term_r == TERM_LFCR) ? CHR_CR : CHR_LF;

  gsof_slot_mem #(.W(SET_W), .D(8), .AW(3)) u_set_mem (
    .i_clk(I_MCLK), .i_ce(I_CE), .i_we(set_we), .i_waddr(cslot),
    .i_wdata(setup_r), .i_raddr(slot_r), .o_rdata(set_rd)
  );
  gsof_slot_mem #(.W(32), .D(8), .AW(3)) u_cbl_mem (
    .i_clk(I_MCLK), .i_ce(I_CE), .i_we(cbl_we), .i_waddr(cslot),
    .i_wdata(cable_r), .i_raddr(slot_r), .o_rdata(cbl_rd)
  );

  // control group: slots, options, hold-off, status, register file
  always_comb begin
    st_nxt = st_r; term_nxt = term_r; k_nxt = k_r; slot_nxt = slot_r;
    cslot_nxt = cslot_r; cbl_nxt = cbl_r; ready_nxt = ready_r; nrfd_nxt = nrfd_r;
    cen_nxt = cen_r; setup_nxt = setup_r; cable_nxt = cable_r; drift_nxt = drift_r;
    rerr_nxt = rerr_r; lerr_nxt = lerr_r; kerr_nxt = kerr_r; dok_nxt = dok_r;
    go_nxt = 1'b0; qn_nxt = qn_r;
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    // error flags clear by writing ones; a new error below still wins
    if (wr && I_WB_ADR == ADR_STAT && I_WB_SEL[0]) begin
      rerr_nxt = rerr_r & ~I_WB_DAT[ST_RANGE_ERR];
      lerr_nxt = lerr_r & ~I_WB_DAT[ST_LOCK_ERR];
      kerr_nxt = kerr_r & ~I_WB_DAT[ST_K_ERR];
    end
    if (wr && I_WB_ADR == ADR_CTRL && I_WB_SEL[0]) begin
      term_nxt = I_WB_DAT[CTRL_TERM_LSB +: 2];
      case (I_WB_DAT[CTRL_K_LSB +: 3])
        K_BOTH, K_NOEOI, K_NOHOLD, K_NONE: k_nxt = I_WB_DAT[CTRL_K_LSB +: 3];
        default: kerr_nxt = 1'b1;
      endcase
    end
    if (wr && I_WB_ADR == ADR_SETUP) setup_nxt = (setup_r & ~wmask) | (I_WB_DAT & wmask);
    if (wr && I_WB_ADR == ADR_CABLE) cable_nxt = (cable_r & ~wmask) | (I_WB_DAT & wmask);
    if (wr && I_WB_ADR == ADR_DRIFT) begin
      drift_nxt = (drift_r & ~wmask) | (I_WB_DAT & wmask);
      dok_nxt = 1'b1;
    end
    case (st_r)
      S_IDLE: begin
        if (cmd_wr) begin
          case (cop)
            OP_RCL_SET: begin
              if (cslot == 3'h0) begin
                setup_nxt = (FACTORY_SETUP & ~FREQ_MASK) | FREQ_100K;
              end else begin
                slot_nxt = cslot;
                cbl_nxt = 1'b0;
                st_nxt = S_READ;
              end
            end
            OP_RCL_CBL: begin
              cslot_nxt = cslot;
              if (cslot == 3'h0) begin
                cen_nxt = 1'b0;
              end else begin
                slot_nxt = cslot;
                cbl_nxt = 1'b1;
                st_nxt = S_READ;
              end
            end
            OP_SAV_SET, OP_SAV_CBL: begin
              if (cslot == 3'h0) rerr_nxt = 1'b1;
            end
            OP_CAL: begin
              qn_nxt = cq;
              if (cq >= Q_LOCK_MIN && cq <= Q_LOCK_MAX && !I_CAL_UNLOCK) begin
                lerr_nxt = 1'b1;
              end else if (cq > Q_LOCK_MAX) begin
                rerr_nxt = 1'b1;
              end else begin
                go_nxt = 1'b1;
              end
            end
            OP_DONE: begin
              ready_nxt = 1'b1;
              nrfd_nxt = 1'b0;
            end
            default: rerr_nxt = 1'b1;
          endcase
        end
      end
      S_READ: st_nxt = S_LOAD; // memory read data registers here
      S_LOAD: begin
        // the whole word comes back, so recall restores every setting at once
        if (cbl_r) begin
          cable_nxt = cbl_rd;
          cen_nxt = 1'b1;
        end else begin
          setup_nxt = set_rd;
        end
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
    // execute wins over a done in the same cycle, so a new hold-off is never lost
    if (I_EXEC) begin
      ready_nxt = 1'b0;
      nrfd_nxt = hold_en;
    end
    // device clear: defaults, then reload setup slot 1
    if (clr) begin
      term_nxt = TERM_CRLF;
      k_nxt = K_BOTH;
      cslot_nxt = 3'h0;
      cen_nxt = 1'b0;
      drift_nxt = 32'h0000_0000;
      dok_nxt = 1'b0;
      slot_nxt = DFLT_SLOT;
      cbl_nxt = 1'b0;
      st_nxt = S_READ;
      go_nxt = 1'b0;
    end
    if (I_RST) begin
      ready_nxt = 1'b1;
      nrfd_nxt = 1'b0;
      rerr_nxt = 1'b0;
      lerr_nxt = 1'b0;
      kerr_nxt = 1'b0;
      setup_nxt = RESET_SETUP;
      cable_nxt = 32'h0000_0000;
      qn_nxt = 4'h0;
      ack_nxt = 1'b0;
    end
    // read mux; unmapped addresses read zero
    if (req && !I_WB_WE) begin
      case (I_WB_ADR)
        ADR_CTRL: dat_nxt = {25'h0, k_r, 2'h0, term_r};
        ADR_SETUP: dat_nxt = setup_r;
        ADR_CABLE: dat_nxt = cable_r;
        ADR_DRIFT: dat_nxt = drift_r;
        ADR_STAT: begin
          dat_nxt[ST_RANGE_ERR] = rerr_r;
          dat_nxt[ST_LOCK_ERR] = lerr_r;
          dat_nxt[ST_K_ERR] = kerr_r;
          dat_nxt[ST_CBL_EN] = cen_r;
          dat_nxt[ST_READY] = ready_r;
          dat_nxt[ST_BUSY] = (st_r != S_IDLE);
          dat_nxt[ST_DRIFT_OK] = dok_r;
          dat_nxt[ST_OUT_DONE] = done_r;
          dat_nxt[ST_TX_BUSY] = (tx_r != TX_IDLE);
          dat_nxt[ST_CSLOT_LSB +: 3] = cslot_r;
        end
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // talker framing group: data byte, then terminator once at the end
  always_comb begin
    tx_nxt = tx_r; txb_nxt = txb_r; txl_nxt = txl_r; done_nxt = done_r;
    odat_nxt = odat_r; oeoi_nxt = 1'b0; ovld_nxt = 1'b0;
    case (tx_r)
      TX_IDLE: begin
        if (wr && I_WB_ADR == ADR_TX && I_WB_SEL[0]) begin
          txb_nxt = I_WB_DAT[7:0];
          txl_nxt = I_WB_DAT[TX_LAST_BIT] & I_WB_SEL[1];
          done_nxt = 1'b0;
          tx_nxt = TX_DATA;
        end
      end
      // items inside a transmission go out bare; only the last gets framing
      TX_DATA: if (xfer) tx_nxt = txl_r ? TX_TERM1 : TX_IDLE;
      TX_TERM1: begin
        if (xfer) begin
          tx_nxt = single ? TX_IDLE : TX_TERM2;
          done_nxt = single;
        end
      end
      TX_TERM2: begin
        if (xfer) begin
          tx_nxt = TX_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: tx_nxt = TX_IDLE;
    endcase
    case (tx_nxt)
      TX_DATA: begin
        ovld_nxt = 1'b1;
        odat_nxt = txb_nxt;
      end
      TX_TERM1: begin
        ovld_nxt = 1'b1;
        odat_nxt = term1;
        oeoi_nxt = eoi_en & single;
      end
      TX_TERM2: begin
        ovld_nxt = 1'b1;
        odat_nxt = term2;
        oeoi_nxt = eoi_en;
      end
      default: odat_nxt = odat_r;
    endcase
    if (I_RST) begin
      tx_nxt = TX_IDLE;
      ovld_nxt = 1'b0;
      oeoi_nxt = 1'b0;
      odat_nxt = 8'h00;
      done_nxt = 1'b0;
      txb_nxt = 8'h00;
      txl_nxt = 1'b0;
    end
  end

  // registers only; reset values come through the next-state logic
  always_ff @(posedge I_MCLK) begin
    if (I_CE || I_RST) begin
      st_r <= st_nxt; tx_r <= tx_nxt; term_r <= term_nxt; k_r <= k_nxt;
      slot_r <= slot_nxt; cslot_r <= cslot_nxt; cbl_r <= cbl_nxt;
      ready_r <= ready_nxt; nrfd_r <= nrfd_nxt; cen_r <= cen_nxt;
      setup_r <= setup_nxt; cable_r <= cable_nxt; drift_r <= drift_nxt;
      rerr_r <= rerr_nxt; lerr_r <= lerr_nxt; kerr_r <= kerr_nxt; dok_r <= dok_nxt;
      ack_r <= ack_nxt; dat_r <= dat_nxt; go_r <= go_nxt; qn_r <= qn_nxt;
      done_r <= done_nxt; txb_r <= txb_nxt; txl_r <= txl_nxt;
      odat_r <= odat_nxt; ovld_r <= ovld_nxt; oeoi_r <= oeoi_nxt;
    end
  end

  // outputs straight from flops
  assign O_WB_DAT = dat_r;
  assign O_WB_ACK = ack_r;
  assign O_NRFD = nrfd_r;
  assign O_READY = ready_r;
  assign O_TX_VALID = ovld_r;
  assign O_TX_DATA = odat_r;
  assign O_TX_EOI = oeoi_r;
  assign O_SETUP = setup_r;
  assign O_CABLE = cable_r;
  assign O_CABLE_EN = cen_r;
  assign O_CAL_GO = go_r;
  assign O_CAL_NUM = qn_r;

  a_slot0_ro: assert property (@(posedge I_MCLK) disable iff (I_RST) (I_CE && cmd_wr && cop == OP_SAV_SET
    && cslot == 3'h0 && st_r == S_IDLE) |-> !set_we ##1 rerr_r) else $error("setup slot 0 written");
  a_cbl_save: assert property (@(posedge I_MCLK) disable iff (I_RST) (I_CE && cmd_wr && cop == OP_SAV_CBL
    && cslot == 3'h0 && st_r == S_IDLE) |-> !cbl_we ##1 rerr_r) else $error("cable slot 0 written");
  a_exec_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && I_EXEC && hold_en) |=> O_NRFD && !O_READY)
    else $error("no hold-off after execute");
  a_done_ready: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && cmd_wr && cop == OP_DONE && st_r == S_IDLE && !clr && !I_EXEC) |=> O_READY && !O_NRFD)
    else $error("ready not restored");
  a_cal_lock: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && cmd_wr && st_r == S_IDLE && cop == OP_CAL && cq >= Q_LOCK_MIN && cq <= Q_LOCK_MAX && !I_CAL_UNLOCK)
    |=> lerr_r && !O_CAL_GO) else $error("locked calibration accepted");
  a_eoi_term: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_TX_EOI |-> O_TX_VALID && (O_TX_DATA == CHR_LF || O_TX_DATA == CHR_CR) && tx_r != TX_DATA)
    else $error("eoi off terminator");
  a_clr_dflt: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && I_DEV_CLR) |=> term_r == TERM_CRLF && k_r == K_BOTH && !O_CABLE_EN && !dok_r ##2 st_r == S_IDLE)
    else $error("device clear defaults wrong");
  a_rcl0_freq: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && cmd_wr && st_r == S_IDLE && cop == OP_RCL_SET && cslot == 3'h0 && !clr)
    |=> (O_SETUP & FREQ_MASK) == FREQ_100K) else $error("slot 0 frequency wrong");
  a_recall_load: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_CE && st_r == S_LOAD && !cbl_r && !clr) |=> O_SETUP == $past(set_rd))
    else $error("recall not restored");
endmodule : gsof_top

// file: tb/gsof_ctl_model.sv
// Purpose: bus controller stand-in that takes talker bytes and sends execute
// Assumes: a byte is taken on an edge with valid and ready both high
// Notes: slow mode stalls ready half the time to test byte holding
module gsof_ctl_model (
  input wire logic i_clk, // clock
  input wire logic i_slow, // stall the acceptor
  input wire logic i_valid, // talker byte valid
  input wire logic [7:0] i_data, // talker byte
  input wire logic i_eoi, // end marker
  input wire logic i_nrfd, // hold-off from device
  output logic o_ready = 1'b0, // byte accepted
  output logic o_exec = 1'b0 // execute character seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];
  logic [1:0] ph_r = 2'h0;
  // capture each byte with its end marker; stalls prove the talker holds
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      rx_q.push_back({i_eoi, i_data});
    end
    ph_r <= ph_r + 2'h1;
    o_ready <= !i_slow || ph_r[1];
  end
  // a further execute only once the device has let go of hold-off
  task automatic send_exec();
    int n;
    n = 0;
    while (i_nrfd !== 1'b0 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    o_exec <= 1'b1;
    @(posedge i_clk);
    o_exec <= 1'b0;
  endtask : send_exec
endmodule : gsof_ctl_model

// file: tb/tb.sv
// Purpose: self-checking bench for slot handling, framing and hold-off
// Assumes: one-cycle wishbone ack, commands accepted when busy is clear
// Notes: slot stores start blank, so slots are saved before recall
module tb
  import gsof_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, dclr = 1'b0, unlock = 1'b0, slow = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, q;
  wire logic [31:0] rdat, setup, cable;
  wire logic ack, nrfd, rdy, tv, teoi, trdy, exec, cen, cgo;
  wire logic [7:0] td;
  wire logic [3:0] cnum;
  int err_total = 0;
  int checked = 0;
  int go_n = 0;
  logic [3:0] go_num;
  gsof_top dut (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hf), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_EXEC(exec), .I_DEV_CLR(dclr), .I_CAL_UNLOCK(unlock), .O_NRFD(nrfd),
    .O_READY(rdy), .O_TX_VALID(tv), .O_TX_DATA(td), .O_TX_EOI(teoi), .I_TX_READY(trdy),
    .O_SETUP(setup), .O_CABLE(cable), .O_CABLE_EN(cen), .O_CAL_GO(cgo), .O_CAL_NUM(cnum));
  gsof_ctl_model ctl (.i_clk(clk), .i_slow(slow), .i_valid(tv), .i_data(td), .i_eoi(teoi),
    .i_nrfd(nrfd), .o_ready(trdy), .o_exec(exec));
  // clock and calibration pulse counter
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (cgo === 1'b1) begin
      go_n++;
      go_num = cnum;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // polling status, since commands during busy are silently dropped
  task automatic poll(input int bitn);
    int n;
    n = 0;
    do begin
      wb(1'h0, ADR_STAT, 32'h0);
      n++;
    end while (q[bitn] !== 1'b0 && n < 30);
    if (q[bitn] !== 1'b0) chk("poll_limit", q[bitn], 1'h0);
  endtask : poll
  task automatic cmd(input logic [2:0] op, input logic [2:0] sl, input logic [3:0] qn);
    poll(ST_BUSY);
    wb(1'h1, ADR_CMD, {20'h0, qn, 1'h0, sl, 1'h0, op});
    poll(ST_BUSY);
  endtask : cmd
  task automatic stat_is(input int bitn, input logic v);
    wb(1'h0, ADR_STAT, 32'h0);
    chk("stat_bit", q[bitn], v);
    wb(1'h1, ADR_STAT, 32'h7);
  endtask : stat_is
  task automatic t_reset();
    chk("ready", rdy, 1'h1);
    chk("nrfd", nrfd, 1'h0);
    chk("cable_en", cen, 1'h0);
    wb(1'h0, ADR_CTRL, 32'h0);
    chk("ctrl", q[6:0], 7'h00);
  endtask : t_reset
  task automatic t_setup();
    wb(1'h1, ADR_SETUP, 32'hcafe_b05a);
    cmd(OP_SAV_SET, 3'h3, 4'h0);
    cmd(OP_SAV_SET, 3'h7, 4'h0);
    wb(1'h1, ADR_SETUP, 32'h1234_5678);
    cmd(OP_SAV_SET, 3'h1, 4'h0);
    cmd(OP_SAV_SET, 3'h0, 4'h0);
    stat_is(ST_RANGE_ERR, 1'h1);
    cmd(OP_RCL_SET, 3'h3, 4'h0);
    chk("setup3", setup, 32'hcafe_b05a);
    cmd(OP_RCL_SET, 3'h1, 4'h0);
    chk("setup1", setup, 32'h1234_5678);
    cmd(OP_RCL_SET, 3'h7, 4'h0);
    chk("setup7", setup, 32'hcafe_b05a);
    cmd(OP_RCL_SET, 3'h0, 4'h0);
    chk("setup0", setup, (FACTORY_SETUP & ~FREQ_MASK) | FREQ_100K);
  endtask : t_setup
  task automatic t_cable();
    wb(1'h1, ADR_CABLE, 32'h0000_7e57);
    cmd(OP_SAV_CBL, 3'h2, 4'h0);
    cmd(OP_SAV_CBL, 3'h0, 4'h0);
    stat_is(ST_RANGE_ERR, 1'h1);
    wb(1'h1, ADR_CABLE, 32'h0);
    cmd(OP_RCL_CBL, 3'h2, 4'h0);
    chk("cable2", cable, 32'h0000_7e57);
    chk("cable_en", cen, 1'h1);
    cmd(OP_RCL_CBL, 3'h0, 4'h0);
    chk("cable_off", cen, 1'h0);
    cmd(OP_RCL_CBL, 3'h2, 4'h0);
    wb(1'h0, ADR_STAT, 32'h0);
    chk("cable_slot", q[ST_CSLOT_LSB +: 3], 3'h2);
  endtask : t_cable
  // device clear with everything moved off its default
  task automatic t_clear();
    wb(1'h1, ADR_SETUP, 32'h0bad_f00d);
    wb(1'h1, ADR_CTRL, 32'h0000_0043);
    wb(1'h1, ADR_DRIFT, 32'h5a5a_5a5a);
    wb(1'h0, ADR_STAT, 32'h0);
    chk("drift_ok", q[ST_DRIFT_OK], 1'h1);
    dclr <= 1'b1;
    @(posedge clk);
    dclr <= 1'b0;
    poll(ST_BUSY);
    chk("clr_setup", setup, 32'h1234_5678);
    chk("clr_cable", cen, 1'h0);
    wb(1'h0, ADR_CTRL, 32'h0);
    chk("clr_ctrl", q[6:0], 7'h00);
    wb(1'h0, ADR_DRIFT, 32'h0);
    chk("clr_drift", q, 32'h0);
  endtask : t_clear
  task automatic t_cal();
    cmd(OP_CAL, 3'h0, 4'h3);
    stat_is(ST_LOCK_ERR, 1'h1);
    chk("cal_locked", go_n, 32'h0);
    cmd(OP_CAL, 3'h0, 4'h0);
    chk("cal_drift", go_n, 32'h1);
    unlock <= 1'b1;
    cmd(OP_CAL, 3'h0, 4'h9);
    chk("cal_go", go_n, 32'h2);
    chk("cal_num", go_num, 4'h9);
    cmd(OP_CAL, 3'h0, 4'ha);
    stat_is(ST_RANGE_ERR, 1'h1);
    chk("cal_range", go_n, 32'h2);
  endtask : t_cal
  // every terminator against every end-marker code; codes 1 and 4 run with the acceptor stalled
  task automatic t_frame();
    logic [7:0] seq[$];
    logic [2:0] kc[4] = '{K_BOTH, K_NOEOI, K_NOHOLD, K_NONE};
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 4; k++) begin
        wb(1'h1, ADR_CTRL, (32'(kc[k]) << CTRL_K_LSB) | 32'(t));
        ctl.rx_q.delete();
        slow <= k[0];
        poll(ST_TX_BUSY);
        wb(1'h1, ADR_TX, 32'h0000_0041);
        poll(ST_TX_BUSY);
        wb(1'h1, ADR_TX, 32'h0000_0142);
        poll(ST_TX_BUSY);
        chk("out_done", q[ST_OUT_DONE], 1'h1);
        case (t)
          0: seq = {8'h41, 8'h42, CHR_CR, CHR_LF};
          1: seq = {8'h41, 8'h42, CHR_LF, CHR_CR};
          2: seq = {8'h41, 8'h42, CHR_CR};
          default: seq = {8'h41, 8'h42, CHR_LF};
        endcase
        chk("frame_len", ctl.rx_q.size(), seq.size());
        for (int i = 0; i < seq.size(); i++) begin
          chk("frame_byte", ctl.rx_q[i][7:0], seq[i]);
          chk("frame_eoi", ctl.rx_q[i][8], i == seq.size() - 1 && k[0] == 1'b0);
        end
      end
    end
    wb(1'h1, ADR_CTRL, 32'h0000_0030);
    stat_is(ST_K_ERR, 1'h1);
  endtask : t_frame
  task automatic t_hold();
    logic [2:0] kc[4] = '{K_BOTH, K_NOEOI, K_NOHOLD, K_NONE};
    for (int k = 0; k < 4; k++) begin
      wb(1'h1, ADR_CTRL, 32'(kc[k]) << CTRL_K_LSB);
      ctl.send_exec();
      repeat (4) @(posedge clk);
      chk("hold", nrfd, k < 2);
      chk("busy_rdy", rdy, 1'h0);
      stat_is(ST_READY, 1'h0);
      cmd(OP_DONE, 3'h0, 4'h0);
      chk("released", nrfd, 1'h0);
      chk("done_rdy", rdy, 1'h1);
    end
  endtask : t_hold
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    poll(ST_BUSY);
    t_reset();
    t_setup();
    t_cable();
    t_clear();
    t_cal();
    t_frame();
    t_hold();
    give_verdict();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : tb
